// [common/split_timer_params.svh]
// Purpose: Offsets, field positions, reset values and counts for the split timer.
// Assumes: Byte-wide special function register bus, 10 MHz system clock.
// Notes: Definitions only.
`ifndef SPLIT_TIMER_PARAMS_SVH
`define SPLIT_TIMER_PARAMS_SVH

`define ADDR_CTRL 8'hC8
`define ADDR_SRC_SEL 8'hC9
`define ADDR_LOW_RELOAD 8'hCA
`define ADDR_HIGH_RELOAD 8'hCB
`define ADDR_LOW_COUNT 8'hCC
`define ADDR_HIGH_COUNT 8'hCD

`define RESET_BYTE 8'h00
`define BYTE_ONES 8'hFF
`define READ_UNMAPPED 8'h00

`define CTRL_HIGH_FLAG 7
`define CTRL_LOW_FLAG 6
`define CTRL_LOW_FLAG_EN 5
`define CTRL_SPLIT 4
`define CTRL_HIGH_CAP 3
`define CTRL_LOW_CAP 2
`define CTRL_HIGH_RUN 1
`define CTRL_LOW_RUN 0

`define SRC_FIRST_LOW_LSB 0
`define SRC_FIRST_HIGH_LSB 2
`define SRC_SECOND_LOW_LSB 4
`define SRC_SECOND_HIGH_LSB 6

`define DIV12_COUNT 4'd12
`define DIV12_LAST 4'd11
`define DIV12_ZERO 4'd0
`define DIV12_ONE 4'd1

`endif

// [common/split_timer_pkg.sv]
// Purpose: Types shared by the split timer design.
// Assumes: Constants come from split_timer_params.svh.
// Notes: Field order of ctrl_s matches the control byte, bit 7 first.
package split_timer_pkg;

  typedef enum logic [1:0] {
    SRC_SYS = 2'b00,
    SRC_DIV12 = 2'b01,
    SRC_RTC_TICK = 2'b10,
    SRC_RTC_PULSE = 2'b11
  } src_e;

  typedef struct packed {
    logic high_half_flag;
    logic low_half_flag;
    logic low_flag_enable;
    logic split_select;
    logic high_half_capture_sel;
    logic low_half_capture_sel;
    logic high_half_run;
    logic low_half_run;
  } ctrl_s;

  typedef struct packed {
    src_e second_high_source;
    src_e second_low_source;
    src_e first_high_source;
    src_e first_low_source;
  } src_sel_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic bit_wr;
    logic [2:0] bit_idx;
    logic bit_val;
  } sfr_req_s;

  typedef struct packed {
    logic rtc_tick;
    logic rtc_pulse;
  } rtc_s;

endpackage : split_timer_pkg

// [hw/split_timer_capture_control.sv]
// Purpose: Split 16-bit or dual 8-bit timer with reload, capture and flags.
// Assumes: Ticks, capture event and bus requests are synchronous to clk_sys.
// Notes: Software writes to a counter byte win over counting in that cycle.
`timescale 1ns/1ps
`include "split_timer_params.svh"

module split_timer_capture_control (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire split_timer_pkg::sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  input wire split_timer_pkg::rtc_s rtc_in,
  input wire logic capture_event,
  output logic timer_irq,
  output split_timer_pkg::src_e second_low_source,
  output split_timer_pkg::src_e second_high_source
);
  import split_timer_pkg::*;

  ctrl_s ctrl_q;
  ctrl_s ctrl_d;
  src_sel_s src_q;
  logic [7:0] low_cnt_q;
  logic [7:0] low_cnt_d;
  logic [7:0] high_cnt_q;
  logic [7:0] high_cnt_d;
  logic [7:0] low_rel_q;
  logic [7:0] low_rel_d;
  logic [7:0] high_rel_q;
  logic [7:0] high_rel_d;
  logic [3:0] div_q;
  logic div12_tick;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Turns a source code into a one-cycle increment enable.
  function automatic logic src_tick(input src_e sel, input logic d12, input rtc_s r);
    logic t;
    t = 1'b0;
    unique case (sel)
      SRC_SYS: t = 1'b1;
      SRC_DIV12: t = d12;
      SRC_RTC_TICK: t = r.rtc_tick;
      SRC_RTC_PULSE: t = r.rtc_pulse;
    endcase
    return t;
  endfunction : src_tick

  // Divide-by-twelve enable: one pulse in every twelve enabled cycles.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= `DIV12_ZERO;
    end else if (clk_en) begin
      div_q <= (div_q == `DIV12_LAST) ? `DIV12_ZERO : div_q + `DIV12_ONE;
    end
  end
  assign div12_tick = (div_q == `DIV12_LAST);

  wire split = ctrl_q.split_select;
  wire wide = !split;
  wire wr_ctrl = sfr_req.wr && (sfr_req.addr == `ADDR_CTRL);
  wire bit_ctrl = sfr_req.bit_wr && (sfr_req.addr == `ADDR_CTRL);
  wire wr_src = sfr_req.wr && (sfr_req.addr == `ADDR_SRC_SEL);
  wire wr_low_rel = sfr_req.wr && (sfr_req.addr == `ADDR_LOW_RELOAD);
  wire wr_high_rel = sfr_req.wr && (sfr_req.addr == `ADDR_HIGH_RELOAD);
  wire wr_low_cnt = sfr_req.wr && (sfr_req.addr == `ADDR_LOW_COUNT);
  wire wr_high_cnt = sfr_req.wr && (sfr_req.addr == `ADDR_HIGH_COUNT);

  // In wide operation the low-half controls govern the whole counter.
  wire low_src_tick = src_tick(src_q.first_low_source, div12_tick, rtc_in);
  wire high_src_tick = src_tick(src_q.first_high_source, div12_tick, rtc_in);
  wire low_inc = ctrl_q.low_half_run && low_src_tick;
  wire low_ovf = low_inc && (low_cnt_q == `BYTE_ONES);
  wire high_inc = wide ? low_ovf : (ctrl_q.high_half_run && high_src_tick);
  wire high_ovf = high_inc && (high_cnt_q == `BYTE_ONES);

  wire low_cap_mode = ctrl_q.low_half_capture_sel;
  wire high_cap_mode = wide ? ctrl_q.low_half_capture_sel : ctrl_q.high_half_capture_sel;
  wire cap_low = capture_event && low_cap_mode;
  wire cap_high = capture_event && high_cap_mode;

  // Wide mode reloads the low byte only together with the high byte.
  wire low_reload = low_ovf && !low_cap_mode && (split || high_ovf);
  wire high_reload = high_ovf && !high_cap_mode;

  wire set_high = (high_ovf && !high_cap_mode) || cap_high;
  wire set_low_split = low_cap_mode ? cap_low : low_ovf;
  wire set_low_wide = low_cap_mode ? high_ovf : low_ovf;
  wire set_low = split ? set_low_split : set_low_wide;

  // Hardware sets win over a software clear in the same cycle.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = ctrl_s'(sfr_req.wdata);
    end
    if (bit_ctrl) begin
      ctrl_d[sfr_req.bit_idx] = sfr_req.bit_val;
    end
    ctrl_d.high_half_flag = ctrl_d.high_half_flag || set_high;
    ctrl_d.low_half_flag = ctrl_d.low_half_flag || set_low;
  end

  assign low_cnt_d = wr_low_cnt ? sfr_req.wdata :
                     low_reload ? low_rel_q :
                     low_inc ? low_cnt_q + 8'h01 : low_cnt_q;
  assign high_cnt_d = wr_high_cnt ? sfr_req.wdata :
                      high_reload ? high_rel_q :
                      high_inc ? high_cnt_q + 8'h01 : high_cnt_q;
  // Capture copies regardless of the run enable.
  assign low_rel_d = cap_low ? low_cnt_q : wr_low_rel ? sfr_req.wdata : low_rel_q;
  assign high_rel_d = cap_high ? high_cnt_q : wr_high_rel ? sfr_req.wdata : high_rel_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= ctrl_s'(`RESET_BYTE);
      src_q <= src_sel_s'(`RESET_BYTE);
      low_cnt_q <= `RESET_BYTE;
      high_cnt_q <= `RESET_BYTE;
      low_rel_q <= `RESET_BYTE;
      high_rel_q <= `RESET_BYTE;
      rdata_q <= `RESET_BYTE;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
      if (wr_src) begin
        src_q <= src_sel_s'(sfr_req.wdata);
      end
      low_cnt_q <= low_cnt_d;
      high_cnt_q <= high_cnt_d;
      low_rel_q <= low_rel_d;
      high_rel_q <= high_rel_d;
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    unique case (sfr_req.addr)
      `ADDR_CTRL: rdata_d = ctrl_q;
      `ADDR_SRC_SEL: rdata_d = src_q;
      `ADDR_LOW_RELOAD: rdata_d = low_rel_q;
      `ADDR_HIGH_RELOAD: rdata_d = high_rel_q;
      `ADDR_LOW_COUNT: rdata_d = low_cnt_q;
      `ADDR_HIGH_COUNT: rdata_d = high_cnt_q;
      default: rdata_d = `READ_UNMAPPED;
    endcase
  end

  assign sfr_rdata = rdata_q;
  assign timer_irq = ctrl_q.high_half_flag ||
                     (ctrl_q.low_half_flag && ctrl_q.low_flag_enable);
  assign second_low_source = src_q.second_low_source;
  assign second_high_source = src_q.second_high_source;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_irq_combine: assert property (
    clk_en && set_high |=> timer_irq
  ) else $error("Interrupt request missed a high flag set.");

  a_flag_sticky: assert property (
    clk_en && ctrl_q.high_half_flag && !wr_ctrl && !bit_ctrl |=> ctrl_q.high_half_flag
  ) else $error("High flag cleared without software.");

  a_set_beats_clear: assert property (
    clk_en && wr_ctrl && !sfr_req.wdata[`CTRL_LOW_FLAG] && set_low |=> ctrl_q.low_half_flag
  ) else $error("Low flag set lost to a clear.");

  a_wide_reload: assert property (
    clk_en && wide && !low_cap_mode && ctrl_q.low_half_run && low_src_tick &&
    {high_cnt_q, low_cnt_q} == 16'hFFFF && !wr_low_cnt && !wr_high_cnt && !wr_low_rel &&
    !wr_high_rel
    |=> {high_cnt_q, low_cnt_q} == {$past(high_rel_q), $past(low_rel_q)} &&
        ctrl_q.high_half_flag
  ) else $error("Wide rollover did not reload and flag.");

  a_split_low_reload: assert property (
    clk_en && split && !low_cap_mode && low_ovf && !wr_low_cnt
    |=> low_cnt_q == $past(low_rel_q) && ctrl_q.low_half_flag
  ) else $error("Split low rollover did not reload.");

  a_split_high_reload: assert property (
    clk_en && split && !ctrl_q.high_half_capture_sel && high_ovf && !wr_high_cnt
    |=> high_cnt_q == $past(high_rel_q) && ctrl_q.high_half_flag
  ) else $error("Split high rollover did not reload.");

  a_capture_copy: assert property (
    clk_en && capture_event && low_cap_mode |=> low_rel_q == $past(low_cnt_q)
  ) else $error("Capture did not copy low count.");

  a_capture_high_copy: assert property (
    clk_en && capture_event && high_cap_mode
    |=> high_rel_q == $past(high_cnt_q) && ctrl_q.high_half_flag
  ) else $error("Capture did not copy high count or flag it.");

  a_split_cap_flag: assert property (
    clk_en && split && low_cap_mode && capture_event |=> ctrl_q.low_half_flag
  ) else $error("Split low capture did not set the low flag.");

  a_wide_low_flag: assert property (
    clk_en && wide && !low_cap_mode && low_ovf |=> ctrl_q.low_half_flag
  ) else $error("Wide low byte wrap did not set the low flag.");

  a_wide_capture_flags: assert property (
    clk_en && wide && low_cap_mode && capture_event && !high_ovf && !ctrl_q.low_half_flag &&
    !wr_ctrl && !bit_ctrl
    |=> ctrl_q.high_half_flag && !ctrl_q.low_half_flag
  ) else $error("Wide capture flags wrong.");

  a_wide_ignores_high: assert property (
    clk_en && wide && !ctrl_q.low_half_run && !wr_high_cnt && !high_reload
    |=> $stable(high_cnt_q)
  ) else $error("High half moved while wide timer stopped.");

  a_high_stop_holds: assert property (
    clk_en && split && !ctrl_q.high_half_run && !wr_high_cnt |=> $stable(high_cnt_q)
  ) else $error("Split high half moved while stopped.");

  a_low_stop_holds: assert property (
    clk_en && !ctrl_q.low_half_run && !wr_low_cnt |=> $stable(low_cnt_q)
  ) else $error("Low half moved while stopped.");

  a_sys_source_count: assert property (
    clk_en && ctrl_q.low_half_run && src_q.first_low_source == SRC_SYS &&
    low_cnt_q != `BYTE_ONES && !wr_low_cnt
    |=> low_cnt_q == $past(low_cnt_q) + 8'h01
  ) else $error("System clock source did not count every cycle.");

  a_div12_spacing: assert property (
    clk_en && div12_tick |=> !div12_tick
  ) else $error("Divide-by-twelve pulse too long.");

  a_low_enable_gate: assert property (
    clk_en && !set_high && !ctrl_q.high_half_flag && !ctrl_q.low_flag_enable &&
    !wr_ctrl && !bit_ctrl
    |=> !timer_irq
  ) else $error("Interrupt request raised by a disabled low flag.");

  a_bit_set: assert property (
    clk_en && bit_ctrl && sfr_req.bit_val |=> ctrl_q[$past(sfr_req.bit_idx)]
  ) else $error("Bit set on control byte failed.");

  a_read_ctrl_data: assert property (
    clk_en && sfr_req.addr == `ADDR_CTRL |=> sfr_rdata == $past(ctrl_q)
  ) else $error("Control byte read data wrong.");

  a_second_src_out: assert property (
    clk_en && wr_src |=> second_low_source == src_e'($past(sfr_req.wdata[5:4])) &&
    second_high_source == src_e'($past(sfr_req.wdata[7:6]))
  ) else $error("Second timer source outputs wrong.");

  a_freeze_state: assert property (
    !clk_en |=> $stable(ctrl_q) && $stable(low_cnt_q) && $stable(high_cnt_q) &&
    $stable(div_q)
  ) else $error("State changed while the clock enable was low.");

endmodule : split_timer_capture_control

// [tb/event_source.sv]
// Purpose: Far-side model giving real-time ticks and capture edge events.
// Assumes: Every pulse lasts one system cycle and starts at a falling edge.
// Notes: Lines return low between pulses; no pull-ups are involved.
`timescale 1ns/1ps
module event_source (
  input wire logic clk_sys,
  output split_timer_pkg::rtc_s rtc_in,
  output logic capture_event
);
  import split_timer_pkg::*;
  initial begin
    rtc_in = '0;
    capture_event = 1'b0;
  end
  // Bit 2 is the capture edge, bit 1 the short tick, bit 0 the long pulse.
  task automatic fire(input logic [2:0] which);
    @(negedge clk_sys);
    rtc_in = which[1:0];
    capture_event = which[2];
    @(negedge clk_sys);
    rtc_in = '0;
    capture_event = 1'b0;
  endtask : fire
endmodule : event_source

// [tb/test_split_timer_capture_control.sv]
// Purpose: Self-checking bench for the split timer control logic.
// Assumes: Pulse sources keep counts deterministic between reads.
// Notes: Clock enable is dropped once to check that state and bus writes freeze.
`timescale 1ns/1ps
`include "split_timer_params.svh"
module test_split_timer_capture_control;
  import split_timer_pkg::*;
  logic clk_sys, reset_n, clk_en, timer_irq, capture_event;
  sfr_req_s sfr_req;
  logic [7:0] sfr_rdata;
  rtc_s rtc_in;
  src_e second_low_source, second_high_source;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  split_timer_capture_control i_split_timer_capture_control (.clk_sys(clk_sys),
    .reset_n(reset_n), .clk_en(clk_en), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .rtc_in(rtc_in), .capture_event(capture_event), .timer_irq(timer_irq),
    .second_low_source(second_low_source), .second_high_source(second_high_source));
  event_source i_event_source (.clk_sys(clk_sys), .rtc_in(rtc_in),
    .capture_event(capture_event));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_req.addr = a;
    sfr_req.wdata = d;
    sfr_req.wr = 1'b1;
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
  endtask : wr
  task automatic bw(input logic [2:0] idx, input logic val);
    @(negedge clk_sys);
    sfr_req.addr = `ADDR_CTRL;
    sfr_req.bit_idx = idx;
    sfr_req.bit_val = val;
    sfr_req.bit_wr = 1'b1;
    @(negedge clk_sys);
    sfr_req.bit_wr = 1'b0;
  endtask : bw
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfr_req.addr = a;
    @(negedge clk_sys);
    chk($sformatf("addr %h", a), sfr_rdata, e);
  endtask : rd
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    sfr_req = '0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) reset_n = 1'b1;
    rd(`ADDR_CTRL, 8'h00);
    rd(`ADDR_SRC_SEL, 8'h00);
    wr(`ADDR_SRC_SEL, 8'hB4);
    rd(`ADDR_SRC_SEL, 8'hB4);
    chk("sources", {4'h0, second_high_source, second_low_source}, 8'h0B);
    // Whole counter runs from the slow pulse only, from 0xFFFE.
    wr(`ADDR_SRC_SEL, 8'h03);
    wr(`ADDR_HIGH_RELOAD, 8'h12);
    wr(`ADDR_LOW_RELOAD, 8'h34);
    wr(`ADDR_HIGH_COUNT, 8'hFF);
    wr(`ADDR_LOW_COUNT, 8'hFE);
    wr(`ADDR_CTRL, 8'h01);
    i_event_source.fire(3'b010);
    rd(`ADDR_LOW_COUNT, 8'hFE);
    i_event_source.fire(3'b001);
    rd(`ADDR_LOW_COUNT, 8'hFF);
    rd(`ADDR_HIGH_COUNT, 8'hFF);
    rd(`ADDR_CTRL, 8'h01);
    i_event_source.fire(3'b001);
    rd(`ADDR_LOW_COUNT, 8'h34);
    rd(`ADDR_HIGH_COUNT, 8'h12);
    rd(`ADDR_CTRL, 8'hC1);
    chk("irq", {7'h0, timer_irq}, 8'h01);
    bw(3'd7, 1'b0);
    rd(`ADDR_CTRL, 8'h41);
    chk("irq", {7'h0, timer_irq}, 8'h00);
    bw(3'd5, 1'b1);
    chk("irq", {7'h0, timer_irq}, 8'h01);
    repeat (20) @(negedge clk_sys);
    rd(`ADDR_CTRL, 8'h61);
    // Split halves, each with its own run bit.
    wr(`ADDR_SRC_SEL, 8'h0F);
    wr(`ADDR_LOW_RELOAD, 8'h77);
    wr(`ADDR_LOW_COUNT, 8'hFF);
    wr(`ADDR_HIGH_COUNT, 8'h20);
    wr(`ADDR_CTRL, 8'h11);
    i_event_source.fire(3'b001);
    rd(`ADDR_LOW_COUNT, 8'h77);
    rd(`ADDR_HIGH_COUNT, 8'h20);
    rd(`ADDR_CTRL, 8'h51);
    wr(`ADDR_CTRL, 8'h12);
    i_event_source.fire(3'b001);
    rd(`ADDR_HIGH_COUNT, 8'h21);
    rd(`ADDR_LOW_COUNT, 8'h77);
    // Split capture on both halves while stopped.
    wr(`ADDR_CTRL, 8'h1C);
    wr(`ADDR_LOW_COUNT, 8'h5A);
    wr(`ADDR_HIGH_COUNT, 8'hA5);
    i_event_source.fire(3'b100);
    rd(`ADDR_LOW_RELOAD, 8'h5A);
    rd(`ADDR_HIGH_RELOAD, 8'hA5);
    rd(`ADDR_CTRL, 8'hDC);
    // Wide capture: the high-half capture bit must be ignored.
    wr(`ADDR_CTRL, 8'h0C);
    wr(`ADDR_LOW_COUNT, 8'h02);
    wr(`ADDR_HIGH_COUNT, 8'h01);
    i_event_source.fire(3'b100);
    rd(`ADDR_LOW_RELOAD, 8'h02);
    rd(`ADDR_HIGH_RELOAD, 8'h01);
    rd(`ADDR_CTRL, 8'h8C);
    wr(`ADDR_LOW_COUNT, 8'hFF);
    wr(`ADDR_HIGH_COUNT, 8'hFF);
    wr(`ADDR_CTRL, 8'h05);
    i_event_source.fire(3'b001);
    rd(`ADDR_LOW_COUNT, 8'h00);
    rd(`ADDR_CTRL, 8'h45);
    // System clock source counts on every cycle of a two-cycle run.
    wr(`ADDR_CTRL, 8'h00);
    wr(`ADDR_SRC_SEL, 8'h00);
    wr(`ADDR_LOW_COUNT, 8'h00);
    wr(`ADDR_HIGH_COUNT, 8'h00);
    wr(`ADDR_CTRL, 8'h01);
    wr(`ADDR_CTRL, 8'h00);
    rd(`ADDR_LOW_COUNT, 8'h02);
    // A flag clear written as the low byte wraps loses to the set.
    wr(`ADDR_CTRL, 8'h01);
    wr(`ADDR_LOW_COUNT, 8'hFE);
    wr(`ADDR_CTRL, 8'h01);
    bw(3'd0, 1'b0);
    rd(`ADDR_CTRL, 8'h40);
    rd(`ADDR_LOW_COUNT, 8'h02);
    // With the clock enable low, counting and bus writes are frozen.
    wr(`ADDR_CTRL, 8'h01);
    clk_en = 1'b0;
    wr(`ADDR_CTRL, 8'h00);
    clk_en = 1'b1;
    wr(`ADDR_CTRL, 8'h00);
    rd(`ADDR_LOW_COUNT, 8'h04);
    // The divided clock gives one count in any twelve enabled cycles.
    wr(`ADDR_SRC_SEL, 8'h01);
    wr(`ADDR_CTRL, 8'h01);
    repeat (10) @(negedge clk_sys);
    wr(`ADDR_CTRL, 8'h00);
    rd(`ADDR_LOW_COUNT, 8'h05);
    // The short tick source ignores the long pulse.
    wr(`ADDR_SRC_SEL, 8'h02);
    wr(`ADDR_CTRL, 8'h01);
    i_event_source.fire(3'b001);
    i_event_source.fire(3'b010);
    wr(`ADDR_CTRL, 8'h00);
    rd(`ADDR_LOW_COUNT, 8'h06);
    // A reset with both halves stopped clears the flags, the request and the low count.
    bw(3'd7, 1'b1);
    chk("irq", {7'h0, timer_irq}, 8'h01);
    @(negedge clk_sys) reset_n = 1'b0;
    @(negedge clk_sys) reset_n = 1'b1;
    chk("irq", {7'h0, timer_irq}, 8'h00);
    rd(`ADDR_CTRL, 8'h00);
    rd(`ADDR_LOW_COUNT, 8'h00);
    close_out();
  end
endmodule : test_split_timer_capture_control
